// *** bench/card_engine_model.sv ***
// Behavioural card engine answering mapper requests
`timescale 1ns/1ps
module card_engine_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic card_req,
	output logic card_done
);
	int d;
	int wait_cnt;
	// Delay rotates 0 to 4 cycles so prompt and slow answers both occur
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			card_done <= 1'b0;
			d <= 0;
			wait_cnt <= 0;
		end else if (card_done) begin
			card_done <= 1'b0;
		end else if (card_req === 1'b1) begin
			if (wait_cnt == d) begin
				card_done <= 1'b1;
				wait_cnt <= 0;
				d <= (d + 3) % 5;
			end else begin
				wait_cnt <= wait_cnt + 1;
			end
		end
	end
endmodule : card_engine_model

// *** bench/mapper_sva.sv ***
// Port checker for the card memory command mapper
`timescale 1ns/1ps
module mapper_sva
	import apdu_map_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [7:0] cmd_ins,
	input wire logic [7:0] cmd_p1,
	input wire logic [7:0] cmd_p2,
	input wire logic [8:0] cmd_len,
	input wire card_family_e card_family,
	input wire logic large_variant,
	input wire logic card_req,
	input wire card_op_e card_op,
	input wire logic [15:0] card_addr,
	input wire logic [8:0] card_len,
	input wire logic [7:0] card_cid,
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_status
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire logic take = cmd_valid && cmd_ready;
	wire logic rd = take && cmd_ins == 8'hB0;
	wire logic bad = rsp_valid && rsp_status != 16'h9000;
	a_cid_fixed: assert property (card_cid == 8'h01)
		else $error("card id not 01");
	a_answer_due: assert property (take |-> ##[1:3] (rsp_valid || card_req))
		else $error("no answer to command");
	a_b2_len_bad: assert property (rd && card_family == FAM_B2 && cmd_len > 9'h020
		|-> ##[1:3] bad) else $error("long read accepted");
	a_b2_zero_len: assert property (rd && card_family == FAM_B2 && cmd_len == 9'h000
		&& cmd_p1 == 8'h00 && cmd_p2 <= 8'h0F |-> ##[1:3] (card_req && card_len == 9'h002))
		else $error("zero length not one block");
	a_uz_len_bad: assert property (take && card_family == FAM_UZ
		&& (cmd_len == 9'h000 || cmd_len > 9'h020) |-> ##[1:3] bad)
		else $error("user zone length accepted");
	a_tag8_align: assert property (card_req && (card_op == OP_TAG_WRITE_E8
		|| card_op == OP_TAG_WRITE_NE8) |-> card_addr[2:0] == 3'h0)
		else $error("block write unaligned");
	a_b8_small: assert property (card_req && card_family == FAM_B8 && !large_variant
		|-> card_addr <= 16'h001F) else $error("small card block over 31");
	a_refuse_quiet: assert property (bad |-> !$past(card_req))
		else $error("refused command reached card");
endmodule : mapper_sva
bind card_memory_apdu_mapper mapper_sva chk (
	.clk(clk),
	.rst(rst),
	.cmd_valid(cmd_valid),
	.cmd_ready(cmd_ready),
	.cmd_ins(cmd_ins),
	.cmd_p1(cmd_p1),
	.cmd_p2(cmd_p2),
	.cmd_len(cmd_len),
	.card_family(card_family),
	.large_variant(large_variant),
	.card_req(card_req),
	.card_op(card_op),
	.card_addr(card_addr),
	.card_len(card_len),
	.card_cid(card_cid),
	.rsp_valid(rsp_valid),
	.rsp_status(rsp_status)
);

// *** bench/tb_card_memory_apdu_mapper.sv ***
// Self-checking bench for the card memory command mapper
`timescale 1ns/1ps
module tb_card_memory_apdu_mapper
	import apdu_map_pkg::*;
;
	localparam logic [15:0] K = 16'h9000;
	localparam logic [15:0] P = 16'h6B00;
	localparam logic [15:0] L = 16'h6700;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid, large_variant, secure_variant, card_done, cmd_ready, card_req, rsp_valid;
	logic [7:0] cmd_ins, cmd_p1, cmd_p2, tag_header, card_substd, card_cid;
	logic [8:0] cmd_len, card_len, rsp_len;
	logic [15:0] card_addr, rsp_status;
	card_family_e card_family;
	card_op_e card_op;
	logic [24:0] qr[$];
	logic [36:0] qc[$];
	logic rq = 1'b0;
	int fails = 0;
	int cmp_count = 0;
	int seed = 93946;
	int tc = 0;
	int r;
	always #4 clk = ~clk;
	card_memory_apdu_mapper uut (
		.clk(clk),
		.rst(rst),
		.cmd_valid(cmd_valid),
		.cmd_ins(cmd_ins),
		.cmd_p1(cmd_p1),
		.cmd_p2(cmd_p2),
		.cmd_len(cmd_len),
		.card_family(card_family),
		.tag_header(tag_header),
		.large_variant(large_variant),
		.secure_variant(secure_variant),
		.card_substd(card_substd),
		.card_done(card_done),
		.cmd_ready(cmd_ready),
		.card_req(card_req),
		.card_op(card_op),
		.card_addr(card_addr),
		.card_len(card_len),
		.card_cid(card_cid),
		.rsp_valid(rsp_valid),
		.rsp_status(rsp_status),
		.rsp_len(rsp_len)
	);
	card_engine_model cem (
		.clk(clk),
		.rst(rst),
		.card_req(card_req),
		.card_done(card_done)
	);
	task give_verdict;
		if (fails == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	task chk_rsp(input logic [24:0] g, input logic [24:0] e);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t status/len got %h exp %h", $time, g, e);
		end
	endtask : chk_rsp
	task chk_card(input logic [36:0] g, input logic [36:0] e);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t op/addr/len/cid got %h exp %h", $time, g, e);
		end
	endtask : chk_card
	// ---------------------------------------------------------------
	// Driver: one command in flight, so queue order matches answers
	// ---------------------------------------------------------------
	task c(input logic [2:0] f, input logic [7:0] i, input logic [15:0] p,
		input logic [8:0] n, input logic [15:0] s);
		logic [3:0] o;
		logic [8:0] l;
		l = (n != 9'h000) ? n : (f == 3'h2) ? 9'h002 : (f == 3'h3) ? 9'h004 : 9'h008;
		if (f == 3'h1)
			o = (n == 9'h008) ? (p[15] ? 4'h4 : 4'h3) : (p[15] ? 4'h2 : 4'h1);
		else if (f == 3'h5)
			o = (i == 8'hB0) ? 4'h7 : 4'h8;
		else
			o = (i == 8'hB0) ? 4'h5 : 4'h6;
		qr.push_back({s, (i == 8'hB0 && s == K) ? l : 9'h000});
		if (s == K)
			qc.push_back({o, (f == 3'h1) ? {1'b0, p[14:0]} : p, l, 8'h01});
		card_family <= card_family_e'(f);
		cmd_ins <= i;
		{cmd_p1, cmd_p2} <= p;
		cmd_len <= n;
		cmd_valid <= 1'b1;
		do @(posedge clk); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		do @(posedge clk); while (rsp_valid !== 1'b1);
	endtask : c
	// ---------------------------------------------------------------
	// Monitor and timeout
	// ---------------------------------------------------------------
	always @(posedge clk) begin
		if (!rst && rsp_valid === 1'b1)
			chk_rsp({rsp_status, rsp_len}, qr.pop_front());
		if (!rst && card_req === 1'b1 && rq !== 1'b1)
			chk_card({card_op, card_addr, card_len, card_cid}, qc.pop_front());
		rq <= card_req;
	end
	always @(posedge clk) begin
		tc++;
		if (tc == 5000) begin
			fails++;
			give_verdict();
		end
	end
	initial begin
		{cmd_valid, large_variant, secure_variant, cmd_ins, cmd_p1, cmd_p2, cmd_len} = '0;
		card_family = FAM_NONE;
		tag_header = 8'h12;
		card_substd = 8'h06;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		c(3'h1,8'hD6,16'h007F,9'h001,K);
		c(3'h1,8'hD6,16'h0080,9'h001,P);
		c(3'h1,8'hD6,16'h8005,9'h001,K);
		c(3'h1,8'hD6,16'h0008,9'h008,K);
		c(3'h1,8'hD6,16'h000C,9'h008,P);
		c(3'h1,8'hD6,16'h8110,9'h008,K);
		tag_header <= 8'h11;
		c(3'h1,8'hD6,16'h0008,9'h008,P);
		c(3'h1,8'hD6,16'h0010,9'h001,K);
		tag_header <= 8'h12;
		c(3'h2,8'hB0,16'h000F,9'h020,K);
		c(3'h2,8'hB0,16'h0010,9'h002,P);
		c(3'h2,8'hB0,16'h0000,9'h022,L);
		c(3'h2,8'hB0,16'h0003,9'h000,K);
		c(3'h2,8'hD6,16'h0007,9'h002,K);
		c(3'h2,8'hD6,16'h0007,9'h004,L);
		c(3'h3,8'hB0,16'h0002,9'h008,K);
		c(3'h3,8'hB0,16'h0002,9'h006,L);
		c(3'h3,8'hB0,16'h0102,9'h004,P);
		c(3'h3,8'hB0,16'h0005,9'h000,K);
		c(3'h3,8'hD6,16'h0005,9'h004,K);
		c(3'h4,8'hB0,16'h001F,9'h010,K);
		c(3'h4,8'hD6,16'h0020,9'h008,P);
		c(3'h4,8'hB0,16'h0001,9'h00C,L);
		c(3'h4,8'hB0,16'h0001,9'h000,K);
		c(3'h4,8'hD6,16'h001F,9'h007,L);
		c(3'h4,8'hD6,16'h001F,9'h008,K);
		card_substd <= 8'h07;
		c(3'h4,8'hB0,16'h0003,9'h008,K);
		secure_variant <= 1'b1;
		c(3'h4,8'hB0,16'h0003,9'h008,16'h6A81);
		secure_variant <= 1'b0;
		large_variant <= 1'b1;
		repeat (4) begin
			r = $random(seed);
			c(3'h4,8'hB0,{8'h00, r[7:0]},{3'h0, r[10:8], 3'h0},K);
		end
		c(3'h5,8'hB0,16'h1234,9'h020,K);
		c(3'h5,8'hB0,16'h1234,9'h021,L);
		c(3'h5,8'hD6,16'hABCD,9'h001,K);
		c(3'h5,8'hD6,16'hABCD,9'h000,L);
		c(3'h2,8'hA4,16'h0000,9'h002,16'h6D00);
		c(3'h0,8'hB0,16'h0000,9'h002,16'h6A81);
		// Let the monitor take the last answer before judging
		repeat (2) @(posedge clk);
		if (qr.size() != 0 || qc.size() != 0)
			fails++;
		give_verdict();
	end
endmodule : tb_card_memory_apdu_mapper

// *** logic/apdu_param_check.sv ***
// Parameter checker: decides the card operation for one command
`timescale 1ns/1ps
`include "apdu_map_regs.svh"
module apdu_param_check
	import apdu_map_pkg::*;
(
	input wire logic is_update,
	input wire card_family_e family,
	input wire logic [7:0] tag_header,
	input wire logic large_variant,
	input wire logic secure_variant,
	input wire logic [7:0] substd,
	input wire logic [7:0] p1,
	input wire logic [7:0] p2,
	input wire logic [8:0] len,
	output card_op_e op,
	output logic [8:0] xfer_len,
	output logic [15:0] addr,
	output logic [15:0] status
);
	logic dyn;
	always_comb begin
		op = OP_NONE;
		xfer_len = len;
		addr = {p1, p2};
		status = `SW_BAD_P1P2;
		dyn = (tag_header[7:4] == `HDR_DYN_HI) && (tag_header != `HDR_STATIC);
		case (family)
			FAM_TAG1: begin
				if (!is_update) begin
					status = `SW_BAD_INS;
				end else if (len == 9'h001) begin
					addr = {8'h00, p2};
					if (p2 > `TAG_MAX_ADDR) begin
						status = `SW_BAD_P1P2;
					end else if (p1 == 8'h00) begin
						op = OP_TAG_WRITE_E;
						status = `SW_OK;
					end else if (p1 == `P1_NOERASE) begin
						op = OP_TAG_WRITE_NE;
						status = `SW_OK;
					end
				end else if (len == 9'h008) begin
					addr = {1'b0, p1[6:0], p2};
					if (!dyn || p2[2:0] != 3'h0) begin
						status = `SW_BAD_P1P2;
					end else begin
						op = p1[7] ? OP_TAG_WRITE_NE8 : OP_TAG_WRITE_E8;
						status = `SW_OK;
					end
				end else begin
					status = `SW_BAD_LEN;
				end
			end
			FAM_B2: begin
				if (p1 != 8'h00 || p2 > `SR2_MAX_BLK) begin
					status = `SW_BAD_P1P2;
				end else if (is_update) begin
					if (len == 9'h002) begin
						op = OP_BLOCK_WRITE;
						status = `SW_OK;
					end else begin
						status = `SW_BAD_LEN;
					end
				end else if (len == 9'h000) begin
					op = OP_BLOCK_READ;
					xfer_len = 9'h002;
					status = `SW_OK;
				end else if (len[0] || len > `SR2_MAX_LEN) begin
					status = `SW_BAD_LEN;
				end else begin
					op = OP_BLOCK_READ;
					status = `SW_OK;
				end
			end
			FAM_B4: begin
				if (p1 != 8'h00) begin
					status = `SW_BAD_P1P2;
				end else if (is_update) begin
					if (len == 9'h004) begin
						op = OP_BLOCK_WRITE;
						status = `SW_OK;
					end else begin
						status = `SW_BAD_LEN;
					end
				end else if (len == 9'h000) begin
					op = OP_BLOCK_READ;
					xfer_len = 9'h004;
					status = `SW_OK;
				end else if (len[1:0] != 2'h0) begin
					status = `SW_BAD_LEN;
				end else begin
					op = OP_BLOCK_READ;
					status = `SW_OK;
				end
			end
			FAM_B8: begin
				// Sub-standard code only identifies the level; both take this path
				if (substd != `SUBSTD_L2 && substd != `SUBSTD_L34) begin
					status = `SW_BAD_CARD;
				end else if (secure_variant) begin
					status = `SW_BAD_CARD;
				end else if (p1 != 8'h00 || (!large_variant && p2 > `B8_SMALL_MAX)) begin
					status = `SW_BAD_P1P2;
				end else if (is_update) begin
					if (len == 9'h008) begin
						op = OP_BLOCK_WRITE;
						status = `SW_OK;
					end else begin
						status = `SW_BAD_LEN;
					end
				end else if (len == 9'h000) begin
					op = OP_BLOCK_READ;
					xfer_len = 9'h008;
					status = `SW_OK;
				end else if (len[2:0] != 3'h0) begin
					status = `SW_BAD_LEN;
				end else begin
					op = OP_BLOCK_READ;
					status = `SW_OK;
				end
			end
			FAM_UZ: begin
				if (len == 9'h000 || len > `UZ_MAX_LEN) begin
					status = `SW_BAD_LEN;
				end else begin
					op = is_update ? OP_UZ_WRITE : OP_UZ_READ;
					status = `SW_OK;
				end
			end
			default: begin
				status = `SW_BAD_CARD;
			end
		endcase
	end
endmodule : apdu_param_check

// *** logic/card_memory_apdu_mapper.sv ***
// Command interpreter mapping read and update commands onto card operations
`timescale 1ns/1ps
`include "apdu_map_regs.svh"
module card_memory_apdu_mapper
	import apdu_map_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_ins,
	input wire logic [7:0] cmd_p1,
	input wire logic [7:0] cmd_p2,
	input wire logic [8:0] cmd_len,
	input wire card_family_e card_family,
	input wire logic [7:0] tag_header,
	input wire logic large_variant,
	input wire logic secure_variant,
	input wire logic [7:0] card_substd,
	input wire logic card_done,
	output logic cmd_ready,
	output logic card_req,
	output card_op_e card_op,
	output logic [15:0] card_addr,
	output logic [8:0] card_len,
	output logic [7:0] card_cid,
	output logic rsp_valid,
	output logic [15:0] rsp_status,
	output logic [8:0] rsp_len
);
	// ----------------------------------------------------------------
	// Command capture and checking
	// ----------------------------------------------------------------
	map_state_e state_ff, nxt_state;
	logic upd_ff, nxt_upd;
	logic [7:0] p1_ff, nxt_p1;
	logic [7:0] p2_ff, nxt_p2;
	logic [8:0] len_ff, nxt_len;
	logic ins_ok_ff, nxt_ins_ok;
	card_op_e op_ff, nxt_op;
	logic [15:0] addr_ff, nxt_addr;
	logic [8:0] clen_ff, nxt_clen;
	logic req_ff, nxt_req;
	logic rsp_ff, nxt_rsp;
	logic [15:0] stat_ff, nxt_stat;
	logic [8:0] rlen_ff, nxt_rlen;
	card_op_e chk_op;
	logic [8:0] chk_len;
	logic [15:0] chk_addr;
	logic [15:0] chk_status;
	logic ready_ff;
	logic [7:0] cid_ff;

	apdu_param_check u_check (
		.is_update(upd_ff),
		.family(card_family),
		.tag_header(tag_header),
		.large_variant(large_variant),
		.secure_variant(secure_variant),
		.substd(card_substd),
		.p1(p1_ff),
		.p2(p2_ff),
		.len(len_ff),
		.op(chk_op),
		.xfer_len(chk_len),
		.addr(chk_addr),
		.status(chk_status)
	);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Page select, system zone and authenticated functions have no op code:
	// the host must reach them over the raw path outside this block.
	always_comb begin
		nxt_state = state_ff;
		nxt_upd = upd_ff;
		nxt_p1 = p1_ff;
		nxt_p2 = p2_ff;
		nxt_len = len_ff;
		nxt_ins_ok = ins_ok_ff;
		nxt_op = op_ff;
		nxt_addr = addr_ff;
		nxt_clen = clen_ff;
		nxt_req = 1'b0;
		nxt_rsp = 1'b0;
		nxt_stat = stat_ff;
		nxt_rlen = rlen_ff;
		case (state_ff)
			ST_IDLE: begin
				// Ready gates the take: an offer in the first cycle after reset waits
				if (cmd_valid && ready_ff) begin
					nxt_upd = (cmd_ins == `INS_UPDATE);
					nxt_ins_ok = (cmd_ins == `INS_UPDATE) || (cmd_ins == `INS_READ);
					nxt_p1 = cmd_p1;
					nxt_p2 = cmd_p2;
					nxt_len = cmd_len;
					nxt_state = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (!ins_ok_ff || chk_op == OP_NONE) begin
					// Refused commands never touch the card
					nxt_stat = ins_ok_ff ? chk_status : `SW_BAD_INS;
					nxt_rlen = 9'h000;
					nxt_rsp = 1'b1;
					nxt_state = ST_DONE;
				end else begin
					nxt_op = chk_op;
					nxt_addr = chk_addr;
					nxt_clen = chk_len;
					nxt_req = 1'b1;
					nxt_state = ST_ISSUE;
				end
			end
			ST_ISSUE: begin
				nxt_req = 1'b1;
				if (card_done) begin
					nxt_req = 1'b0;
					nxt_stat = `SW_OK;
					nxt_rlen = upd_ff ? 9'h000 : clen_ff;
					nxt_rsp = 1'b1;
					nxt_state = ST_DONE;
				end
			end
			ST_DONE: begin
				nxt_op = OP_NONE;
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			upd_ff <= 1'b0;
			p1_ff <= 8'h00;
			p2_ff <= 8'h00;
			len_ff <= 9'h000;
			ins_ok_ff <= 1'b0;
			op_ff <= OP_NONE;
			addr_ff <= 16'h0000;
			clen_ff <= 9'h000;
			req_ff <= 1'b0;
			rsp_ff <= 1'b0;
			stat_ff <= 16'h0000;
			rlen_ff <= 9'h000;
		end else begin
			state_ff <= nxt_state;
			upd_ff <= nxt_upd;
			p1_ff <= nxt_p1;
			p2_ff <= nxt_p2;
			len_ff <= nxt_len;
			ins_ok_ff <= nxt_ins_ok;
			op_ff <= nxt_op;
			addr_ff <= nxt_addr;
			clen_ff <= nxt_clen;
			req_ff <= nxt_req;
			rsp_ff <= nxt_rsp;
			stat_ff <= nxt_stat;
			rlen_ff <= nxt_rlen;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ready_ff <= 1'b0;
			cid_ff <= `UZ_CID;
		end else begin
			ready_ff <= (nxt_state == ST_IDLE);
			cid_ff <= `UZ_CID;
		end
	end

	assign cmd_ready = ready_ff;
	assign card_req = req_ff;
	assign card_op = op_ff;
	assign card_addr = addr_ff;
	assign card_len = clen_ff;
	assign card_cid = cid_ff;
	assign rsp_valid = rsp_ff;
	assign rsp_status = stat_ff;
	assign rsp_len = rlen_ff;
endmodule : card_memory_apdu_mapper

// *** shared/apdu_map_pkg.sv ***
// Types for the card memory command mapper
package apdu_map_pkg;
	typedef enum logic [2:0] {
		FAM_NONE = 3'h0,
		FAM_TAG1 = 3'h1,
		FAM_B2 = 3'h2,
		FAM_B4 = 3'h3,
		FAM_B8 = 3'h4,
		FAM_UZ = 3'h5
	} card_family_e;
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_TAG_WRITE_E = 4'h1,
		OP_TAG_WRITE_NE = 4'h2,
		OP_TAG_WRITE_E8 = 4'h3,
		OP_TAG_WRITE_NE8 = 4'h4,
		OP_BLOCK_READ = 4'h5,
		OP_BLOCK_WRITE = 4'h6,
		OP_UZ_READ = 4'h7,
		OP_UZ_WRITE = 4'h8
	} card_op_e;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CHECK = 2'b01,
		ST_ISSUE = 2'b11,
		ST_DONE = 2'b10
	} map_state_e;
endpackage : apdu_map_pkg

// *** shared/apdu_map_regs.svh ***
// Constants for the card memory command mapper
// Notes on behaviour
// - Tag byte write P1=00, addr 0..127
// - Tag byte P1=80 does XOR write
// - Dynamic tag 8-byte erase write, aligned
// - P1 high bit: 8-byte XOR write
// - 2-byte cards: P1=00, block 0..15, Le<=32 even
// - 2-byte cards: Le zero returns 2
// - 2-byte cards update: Lc exactly 2
// - 4-byte cards read: P1=00, Le multiple 4
// - 4-byte cards: Le zero returns 4
// - 4-byte cards update: Lc exactly 4
// - 8-byte cards: block max 31 or 255
// - 8-byte cards read: Le multiple 8
// - 8-byte cards: Le zero returns 8
// - 8-byte cards update: Lc exactly 8
// - Sub-standard 06 and 07 handled alike
// - Only non-secure 8-byte variants supported
// - No native page select command
// - User-zone cards activated with identifier 01
// - User-zone read 1..32 bytes, user read
// - User-zone write 1..32 bytes, user write
// - No system zone or authenticated access
// - Header byte 11 static, 1y dynamic
`ifndef APDU_MAP_REGS_SVH
`define APDU_MAP_REGS_SVH
`define INS_READ 8'hB0
`define INS_UPDATE 8'hD6
`define P1_NOERASE 8'h80
`define TAG_MAX_ADDR 8'h7F
`define HDR_STATIC 8'h11
`define HDR_DYN_HI 4'h1
`define SR2_MAX_BLK 8'h0F
`define SR2_MAX_LEN 9'h020
`define B8_SMALL_MAX 8'h1F
`define UZ_MAX_LEN 9'h020
`define SUBSTD_L2 8'h06
`define SUBSTD_L34 8'h07
`define UZ_CID 8'h01
`define SW_OK 16'h9000
`define SW_BAD_P1P2 16'h6B00
`define SW_BAD_LEN 16'h6700
`define SW_BAD_INS 16'h6D00
`define SW_BAD_CARD 16'h6A81
`endif
